// File: inc/cpfs_defs.svh
// Register offsets, field positions, reset values and rule notes for the pin function select block.
// Notes on behaviour
// - Keeper bit 0 enables the serial-output bus keeper, 1 disables; resets to 1.
// - Output function 000 powers down the serial-output buffer; nothing driven.
// - Output function 001 (reset) drives primary audio-interface serial data.
// - Output function 010 drives a general-purpose level from the output value bit.
// - Output function 011 routes the internal clock output to the pin.
// - Output functions 100 and 101 drive the first and second interrupt lines.
// - Output functions 110 and 111 drive secondary bit clock and word clock.
// - General-purpose output level follows the value bit, which resets to 0.
// - Input mode 00 powers down the serial-input buffer.
// - Input mode 01 (reset) offers the pin to data, microphone and clock generator; the code offers it to audio data only.
// - Input mode 10 makes a general input; read-only bit returns buffer level.
// - Five-bit DAC program field selects programs; resets to program one.
`ifndef CPFS_DEFS_SVH
`define CPFS_DEFS_SVH

`define CPFS_IDX_OUT_CTRL   8'h35
`define CPFS_IDX_IN_CTRL    8'h36
`define CPFS_IDX_RSVD_A     8'h37
`define CPFS_IDX_RSVD_B     8'h38
`define CPFS_IDX_RSVD_C     8'h39
`define CPFS_IDX_RSVD_D     8'h3A
`define CPFS_IDX_RSVD_E     8'h3B
`define CPFS_IDX_DAC_PROG   8'h3C

`define CPFS_RST_OUT_CTRL   8'h12
`define CPFS_RST_IN_CTRL    8'h02
`define CPFS_RST_RSVD_A     8'h02
`define CPFS_RST_RSVD_B     8'h02
`define CPFS_RST_RSVD_C     8'h00
`define CPFS_RST_RSVD_D     8'h00
`define CPFS_RST_RSVD_E     8'h00
`define CPFS_RST_DAC_PROG   8'h01

`define CPFS_KEEPER_BIT     4
`define CPFS_OUT_FN_HI      3
`define CPFS_OUT_FN_LO      1
`define CPFS_OUT_VAL_BIT    0
`define CPFS_IN_MODE_HI     2
`define CPFS_IN_MODE_LO     1
`define CPFS_IN_LEVEL_BIT   0
`define CPFS_PROG_HI        4

`define CPFS_OUT_FN_OFF     3'h0
`define CPFS_OUT_FN_PRI     3'h1
`define CPFS_OUT_FN_GPO     3'h2
`define CPFS_OUT_FN_CLK     3'h3
`define CPFS_OUT_FN_FIRST_INTERRUPT_LINE    3'h4
`define CPFS_OUT_FN_SECOND_INTERRUPT_LINE    3'h5
`define CPFS_OUT_FN_SBCLK   3'h6
`define CPFS_OUT_FN_SWCLK   3'h7

`define CPFS_IN_MODE_OFF    2'h0
`define CPFS_IN_MODE_AUDIO  2'h1
`define CPFS_IN_MODE_GPI    2'h2

`endif

// File: inc/cpfs_pkg.sv
// Types shared by the pin function select block.
package cpfs_pkg;

	typedef struct packed {
		logic primary_data;
		logic clock_output_signal;
		logic first_interrupt_line;
		logic second_interrupt_line;
		logic secondary_bclk;
		logic secondary_wclk;
	} cpfs_src_t;

	typedef struct packed {
		logic audio_data;
		logic general_input;
	} cpfs_in_use_t;

	typedef enum logic [2:0] {
		CPFS_IDLE   = 3'b001,
		CPFS_ACCESS = 3'b010,
		CPFS_DONE   = 3'b100
	} cpfs_state_t;

endpackage : cpfs_pkg

// File: src/cpfs_in_sync.sv
// Three-stage synchroniser for the serial-input pin with second/third stage agreement.
`timescale 1ns/1ps
`default_nettype none
module cpfs_in_sync (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic pin_in,
	output var  logic level
);

	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= pin_in;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// The level changes only once the last two stages agree.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			level <= 1'b0;
		end else if (s2 == s3) begin
			level <= s3;
		end
	end

endmodule : cpfs_in_sync
`default_nettype wire

// File: src/cpfs_top.sv
// APB register block and pin function multiplexer for the serial pins.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "cpfs_defs.svh"
module cpfs_top (
	input  wire logic               core_clk,
	input  wire logic               rst,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	input  wire logic [3:0]         pstrb,
	output var  logic               pready,
	output var  logic [31:0]        prdata,
	output var  logic               pslverr,
	input  wire cpfs_pkg::cpfs_src_t src,
	output var  logic               out_pin_o,
	output var  logic               out_pin_oe,
	output var  logic               out_keeper_en,
	input  wire logic               in_pin_i,
	output var  logic               in_buf_en,
	output var  cpfs_pkg::cpfs_in_use_t in_use,
	output var  logic               in_audio_data,
	output var  logic [4:0]         dac_program
);

	//------------------------------------------------------------
	// Registers
	//------------------------------------------------------------

	logic [7:0]             out_ctrl;
	logic [7:0]             in_ctrl;
	logic [7:0]             rsvd [5];
	logic [7:0]             dac_prog;
	logic                   in_level;
	logic                   in_raw_level;
	cpfs_pkg::cpfs_state_t  state;
	logic                   wr_go;
	logic                   rd_go;
	logic                   hit;
	logic [7:0]             rd_byte;
	logic [2:0]             out_fn;
	logic [1:0]             in_mode;

	function automatic logic [7:0] idx_of(input logic [11:0] a);
		idx_of = a[9:2];
	endfunction : idx_of

	function automatic logic mapped(input logic [11:0] a);
		mapped = (a[1:0] == 2'h0) && (a[11:10] == 2'h0)
			&& (idx_of(a) >= `CPFS_IDX_OUT_CTRL) && (idx_of(a) <= `CPFS_IDX_DAC_PROG);
	endfunction : mapped

	assign out_fn  = out_ctrl[`CPFS_OUT_FN_HI:`CPFS_OUT_FN_LO];
	assign in_mode = in_ctrl[`CPFS_IN_MODE_HI:`CPFS_IN_MODE_LO];

	//------------------------------------------------------------
	// APB slave
	//------------------------------------------------------------

	// One wait state: setup, access, then done with pready high.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state <= cpfs_pkg::CPFS_IDLE;
		end else begin
			case (state)
				cpfs_pkg::CPFS_IDLE:   state <= (psel && !penable) ? cpfs_pkg::CPFS_ACCESS : cpfs_pkg::CPFS_IDLE;
				cpfs_pkg::CPFS_ACCESS: state <= (psel && penable) ? cpfs_pkg::CPFS_DONE : cpfs_pkg::CPFS_ACCESS;
				cpfs_pkg::CPFS_DONE:   state <= (psel && !penable) ? cpfs_pkg::CPFS_ACCESS : cpfs_pkg::CPFS_IDLE;
				default:               state <= cpfs_pkg::CPFS_IDLE;
			endcase
		end
	end

	assign pready  = (state == cpfs_pkg::CPFS_DONE) && psel && penable;
	assign hit     = mapped(paddr);
	assign wr_go   = pready && pwrite && hit && pstrb[0];
	assign rd_go   = pready && !pwrite;
	assign pslverr = pready && !hit;

	always_comb begin
		rd_byte = 8'h00;
		if (idx_of(paddr) == `CPFS_IDX_OUT_CTRL) begin
			rd_byte = out_ctrl;
		end else if (idx_of(paddr) == `CPFS_IDX_IN_CTRL) begin
			rd_byte = {in_ctrl[7:1], in_level};
		end else if (idx_of(paddr) == `CPFS_IDX_DAC_PROG) begin
			rd_byte = dac_prog;
		end else if (idx_of(paddr) >= `CPFS_IDX_RSVD_A && idx_of(paddr) <= `CPFS_IDX_RSVD_E) begin
			rd_byte = rsvd[3'(idx_of(paddr) - `CPFS_IDX_RSVD_A)];
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (state == cpfs_pkg::CPFS_ACCESS && psel && penable && !pwrite) begin
			prdata <= hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

	//------------------------------------------------------------
	// Control registers
	//------------------------------------------------------------

	always_ff @(posedge core_clk) begin
		if (rst) begin
			out_ctrl <= `CPFS_RST_OUT_CTRL;
		end else if (wr_go && idx_of(paddr) == `CPFS_IDX_OUT_CTRL) begin
			out_ctrl <= pwdata[7:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			in_ctrl <= `CPFS_RST_IN_CTRL;
		end else if (wr_go && idx_of(paddr) == `CPFS_IDX_IN_CTRL) begin
			in_ctrl <= {pwdata[7:1], 1'b0};
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			dac_prog <= `CPFS_RST_DAC_PROG;
		end else if (wr_go && idx_of(paddr) == `CPFS_IDX_DAC_PROG) begin
			dac_prog <= pwdata[7:0];
		end
	end

	// Reserved registers hold what the host writes; only reset values are expected.
	generate
		for (genvar g = 0; g < 5; g++) begin : g_rsvd
			localparam logic [7:0] RV = (g == 0) ? `CPFS_RST_RSVD_A : (g == 1) ? `CPFS_RST_RSVD_B
				: (g == 2) ? `CPFS_RST_RSVD_C : (g == 3) ? `CPFS_RST_RSVD_D : `CPFS_RST_RSVD_E;
			always_ff @(posedge core_clk) begin
				if (rst) begin
					rsvd[g] <= RV;
				end else if (wr_go && idx_of(paddr) == 8'(`CPFS_IDX_RSVD_A + g)) begin
					rsvd[g] <= pwdata[7:0];
				end
			end
		end
	endgenerate

	//------------------------------------------------------------
	// Output pin multiplexer
	//------------------------------------------------------------

	assign out_keeper_en = !out_ctrl[`CPFS_KEEPER_BIT];

	always_ff @(posedge core_clk) begin
		if (rst) begin
			out_pin_o  <= 1'b0;
			out_pin_oe <= 1'b0;
		end else begin
			out_pin_oe <= (out_fn != `CPFS_OUT_FN_OFF);
			case (out_fn)
				`CPFS_OUT_FN_OFF:   out_pin_o <= 1'b0;
				`CPFS_OUT_FN_PRI:   out_pin_o <= src.primary_data;
				`CPFS_OUT_FN_GPO:   out_pin_o <= out_ctrl[`CPFS_OUT_VAL_BIT];
				`CPFS_OUT_FN_CLK:   out_pin_o <= src.clock_output_signal;
				`CPFS_OUT_FN_FIRST_INTERRUPT_LINE:  out_pin_o <= src.first_interrupt_line;
				`CPFS_OUT_FN_SECOND_INTERRUPT_LINE:  out_pin_o <= src.second_interrupt_line;
				`CPFS_OUT_FN_SBCLK: out_pin_o <= src.secondary_bclk;
				default:            out_pin_o <= src.secondary_wclk;
			endcase
		end
	end

	//------------------------------------------------------------
	// Input pin
	//------------------------------------------------------------

	cpfs_in_sync u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.pin_in   (in_pin_i),
		.level    (in_raw_level)
	);

	assign in_buf_en = (in_mode != `CPFS_IN_MODE_OFF);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			in_level      <= 1'b0;
			in_use        <= '0;
			in_audio_data <= 1'b0;
		end else begin
			in_level             <= in_buf_en ? in_raw_level : 1'b0;
			in_use.audio_data    <= (in_mode == `CPFS_IN_MODE_AUDIO);
			in_use.general_input <= (in_mode == `CPFS_IN_MODE_GPI);
			in_audio_data        <= (in_mode == `CPFS_IN_MODE_AUDIO) ? in_raw_level : 1'b0;
		end
	end

	assign dac_program = dac_prog[`CPFS_PROG_HI:0];

	//------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------

	sequence s_write(logic [7:0] idx);
		wr_go && idx_of(paddr) == idx;
	endsequence

	property p_keeper;
		@(posedge core_clk) disable iff (rst)
		s_write(`CPFS_IDX_OUT_CTRL) |=> out_keeper_en == !$past(pwdata[4]);
	endproperty
	a_keeper: assert property (p_keeper) else $error("keeper enable wrong");

	property p_off;
		@(posedge core_clk) disable iff (rst)
		(out_fn == `CPFS_OUT_FN_OFF) |=> !out_pin_oe;
	endproperty
	a_off: assert property (p_off) else $error("output driven while off");

	property p_pri;
		@(posedge core_clk) disable iff (rst)
		(out_fn == `CPFS_OUT_FN_PRI) |=> out_pin_oe && out_pin_o == $past(src.primary_data);
	endproperty
	a_pri: assert property (p_pri) else $error("primary data not routed");

	property p_gpo;
		@(posedge core_clk) disable iff (rst)
		(out_fn == `CPFS_OUT_FN_GPO) |=> out_pin_o == $past(out_ctrl[0]);
	endproperty
	a_gpo: assert property (p_gpo) else $error("general output level wrong");

	property p_clk;
		@(posedge core_clk) disable iff (rst)
		(out_fn == `CPFS_OUT_FN_CLK) |=> out_pin_o == $past(src.clock_output_signal);
	endproperty
	a_clk: assert property (p_clk) else $error("clock output not routed");

	property p_second_interrupt_line;
		@(posedge core_clk) disable iff (rst)
		(out_fn == `CPFS_OUT_FN_SECOND_INTERRUPT_LINE) |=> out_pin_o == $past(src.second_interrupt_line);
	endproperty
	a_second_interrupt_line: assert property (p_second_interrupt_line) else $error("second interrupt not routed");

	property p_first_interrupt_line;
		@(posedge core_clk) disable iff (rst)
		(out_fn == `CPFS_OUT_FN_FIRST_INTERRUPT_LINE) |=> out_pin_o == $past(src.first_interrupt_line);
	endproperty
	a_first_interrupt_line: assert property (p_first_interrupt_line) else $error("first interrupt not routed");

	property p_swclk;
		@(posedge core_clk) disable iff (rst)
		(out_fn == `CPFS_OUT_FN_SWCLK) |=> out_pin_o == $past(src.secondary_wclk);
	endproperty
	a_swclk: assert property (p_swclk) else $error("secondary word clock not routed");

	property p_sbclk;
		@(posedge core_clk) disable iff (rst)
		(out_fn == `CPFS_OUT_FN_SBCLK) |=> out_pin_o == $past(src.secondary_bclk);
	endproperty
	a_sbclk: assert property (p_sbclk) else $error("secondary bit clock not routed");

	property p_in_off;
		@(posedge core_clk) disable iff (rst)
		(in_mode == `CPFS_IN_MODE_OFF)[*2] |-> !in_level && !in_buf_en;
	endproperty
	a_in_off: assert property (p_in_off) else $error("input buffer not off");

	property p_prog;
		@(posedge core_clk) disable iff (rst)
		s_write(`CPFS_IDX_DAC_PROG) |=> dac_program == $past(pwdata[4:0]);
	endproperty
	a_prog: assert property (p_prog) else $error("program select not stored");

	property p_drive;
		@(posedge core_clk) disable iff (rst)
		(out_fn != `CPFS_OUT_FN_OFF) |=> out_pin_oe;
	endproperty
	a_drive: assert property (p_drive) else $error("output not driven");

	property p_keeper_hold;
		@(posedge core_clk) disable iff (rst)
		!(wr_go && idx_of(paddr) == `CPFS_IDX_OUT_CTRL) |=> $stable(out_keeper_en);
	endproperty
	a_keeper_hold: assert property (p_keeper_hold) else $error("keeper enable changed without write");

	property p_in_audio;
		@(posedge core_clk) disable iff (rst)
		(in_mode == `CPFS_IN_MODE_AUDIO) |=> in_use.audio_data && in_audio_data == $past(in_raw_level);
	endproperty
	a_in_audio: assert property (p_in_audio) else $error("audio input not offered");

	property p_in_gpi;
		@(posedge core_clk) disable iff (rst)
		(in_mode == `CPFS_IN_MODE_GPI) |=> in_use.general_input && in_level == $past(in_raw_level);
	endproperty
	a_in_gpi: assert property (p_in_gpi) else $error("general input level wrong");

	sequence s_read_in;
		rd_go && hit && idx_of(paddr) == `CPFS_IDX_IN_CTRL;
	endsequence

	property p_rd_in;
		@(posedge core_clk) disable iff (rst)
		s_read_in |-> prdata == {24'h00_0000, in_ctrl[7:1], $past(in_level)};
	endproperty
	a_rd_in: assert property (p_rd_in) else $error("input level read back wrong");

endmodule : cpfs_top
`default_nettype wire

// File: testbench/cpfs_far_model.sv
// Model of the audio interface, interrupt and clock sources and the serial-input pin driver.
`timescale 1ns/1ps
`default_nettype none
module cpfs_far_model (
	input  wire logic              core_clk,
	input  wire logic [6:0]        drv,
	output var  cpfs_pkg::cpfs_src_t src,
	output var  logic              in_pin
);
	// ----------------------------------------------------------------
	// Source signals change only on the core clock, as same-clock inputs.
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		src    <= drv[5:0];
		in_pin <= drv[6];
	end
endmodule : cpfs_far_model
`default_nettype wire

// File: testbench/codec_pin_function_select_tb.sv
// Self-checking testbench for the pin function select block.
`timescale 1ns/1ps
`default_nettype none
module codec_pin_function_select_tb;
	logic                   core_clk = 1'b0;
	logic                   rst      = 1'b1;
	logic                   psel     = 1'b0;
	logic                   penable  = 1'b0;
	logic                   pwrite   = 1'b0;
	logic [11:0]            paddr    = 12'h000;
	logic [31:0]            pwdata   = 32'h00000000;
	logic [3:0]             pstrb    = 4'h0;
	logic                   pready, pslverr, out_pin_o, out_pin_oe, out_keeper_en, in_pin_i, in_buf_en, in_audio_data;
	logic [31:0]            prdata, rd;
	logic [4:0]             dac_program;
	cpfs_pkg::cpfs_src_t    src;
	cpfs_pkg::cpfs_in_use_t in_use;
	logic [6:0]             drv      = 7'h00;
	logic [31:0]            seed     = 32'h00000EC7;
	logic                   er, p, ex;
	logic [2:0]             f;
	logic [1:0]             m;
	logic [7:0]             b;
	int                     err_total = 0, total_checks = 0, cyc = 0, i;
	int                     mdl [8];
	localparam logic [7:0]  RV [8] = '{8'h12, 8'h02, 8'h02, 8'h02, 8'h00, 8'h00, 8'h00, 8'h01};
	localparam logic [7:0]  PROGS [6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h18, 8'h19};

	cpfs_top i_cpfs_top (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.src(src), .out_pin_o(out_pin_o), .out_pin_oe(out_pin_oe), .out_keeper_en(out_keeper_en),
		.in_pin_i(in_pin_i), .in_buf_en(in_buf_en), .in_use(in_use), .in_audio_data(in_audio_data),
		.dac_program(dac_program));
	cpfs_far_model i_cpfs_far_model (.core_clk(core_clk), .drv(drv), .src(src), .in_pin(in_pin_i));

	always #2 core_clk = ~core_clk;

	// ----------------------------------------------------------------
	// Helpers.
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction : xs

	function automatic logic [11:0] addr(input int k);
		return 12'(4 * (53 + k));
	endfunction : addr

	task automatic results;
		if (err_total == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			$display("ERROR %0t got %h expected %h", $time, g, e);
			err_total++;
		end
	endtask : chk

	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h000000, d};
		pstrb   <= s;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd      = prdata;
		er      = pslverr;
		if (w && s[0] && a[1:0] == 2'h0 && a >= addr(0) && a <= addr(7))
			mdl[(a >> 2) - 53] = d;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			results();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence.
	// ----------------------------------------------------------------
	initial begin
		for (i = 0; i < 8; i++)
			mdl[i] = int'(RV[i]);
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		for (i = 0; i < 8; i++) begin
			apb(1'b0, addr(i), 8'h00, 4'hF);
			chk(rd, mdl[i]);
			chk(er, 1'b0);
		end
		#1;
		chk(out_keeper_en, 1'b0);
		chk(out_pin_oe, 1'b1);
		chk(in_buf_en, 1'b1);
		chk(dac_program, 5'h01);
		for (i = 0; i < 16; i++) begin
			seed = xs(seed);
			f = i[2:0];
			b = {3'h0, seed[8], f, seed[7]};
			drv <= seed[6:0];
			apb(1'b1, addr(0), b, 4'h1);
			repeat (4) @(posedge core_clk);
			#1;
			ex = (f == 3'h1) ? drv[5] : (f == 3'h2) ? b[0] : drv[7 - f];
			chk(out_keeper_en, !b[4]);
			chk(out_pin_oe, f != 3'h0);
			if (f != 3'h0)
				chk(out_pin_o, ex);
			apb(1'b0, addr(0), 8'h00, 4'hF);
			chk(rd, mdl[0]);
		end
		for (i = 0; i < 6; i++) begin
			m = 2'(i >> 1);
			p = i[0];
			drv <= {p, 6'h00};
			apb(1'b1, addr(1), {5'h00, m, 1'b0}, 4'h1);
			repeat (8) @(posedge core_clk);
			#1;
			chk(in_buf_en, m != 2'h0);
			chk(in_use, {m == 2'h1, m == 2'h2});
			chk(in_audio_data, m == 2'h1 && p);
			apb(1'b0, addr(1), 8'h00, 4'hF);
			chk(rd, {29'h0, m, m != 2'h0 && p});
		end
		for (i = 0; i < 6; i++) begin
			apb(1'b1, addr(7), PROGS[i], 4'h1);
			#1;
			chk(dac_program, PROGS[i][4:0]);
			apb(1'b0, addr(7), 8'h00, 4'hF);
			chk(rd, mdl[7]);
		end
		apb(1'b1, addr(6), 8'h00, 4'h1);
		apb(1'b0, addr(6), 8'h00, 4'hF);
		chk(rd, mdl[6]);
		apb(1'b0, 12'h100, 8'h00, 4'hF);
		chk(er, 1'b1);
		chk(rd, 32'h00000000);
		apb(1'b1, 12'hF1, 8'h01, 4'h1);
		chk(er, 1'b1);
		apb(1'b1, addr(7), 8'h03, 4'h0);
		apb(1'b0, addr(7), 8'h00, 4'hF);
		chk(rd, mdl[7]);
		chk(er, 1'b0);
		results();
	end
endmodule : codec_pin_function_select_tb
`default_nettype wire
